/* File: dv/sdram_pin_command_interface_properties.sv */
`timescale 1ns/10ps
module sdram_pin_command_interface_properties
	import sdram_pin_pkg::*;
#(
	parameter int DATA_W = DQ_W_DEFAULT
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// link pins
	input wire logic clock_gate,
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_strobe_n,
	input wire logic low_byte_mask,
	input wire logic high_byte_mask,
	input wire logic [DATA_W-1:0] ctrl_data_oe,
	input wire logic [DATA_W-1:0] dev_data_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic [CMD_W-1:0] cmd;
	logic rd;
	logic wr;
	assign cmd = {row_strobe_n, col_strobe_n, write_strobe_n};
	assign rd = clock_gate && !chip_select_n && cmd == CMD_READ;
	assign wr = clock_gate && !chip_select_n && cmd == CMD_WRITE;
	property p_reset_idle;
		$rose(nrst) |-> chip_select_n && cmd == CMD_NOP && clock_gate && ctrl_data_oe == '0;
	endproperty
	property p_low_float;
		clock_gate && low_byte_mask ##1 clock_gate |=> dev_data_oe[BYTE_W-1:0] == '0;
	endproperty
	property p_high_float;
		clock_gate && high_byte_mask ##1 clock_gate |=> dev_data_oe[DATA_W-1:BYTE_W] == '0;
	endproperty
	property p_read_latency;
		rd && !low_byte_mask && !high_byte_mask ##1 clock_gate |=> dev_data_oe == '1;
	endproperty
	property p_data_source;
		$rose(|dev_data_oe) && $past(clock_gate) && $past(clock_gate, 2)
			|-> $past(rd, 2);
	endproperty
	property p_suspend_hold;
		!clock_gate |=> $stable(dev_data_oe);
	endproperty
	property p_write_drive;
		wr |-> ctrl_data_oe != '0;
	endproperty
	property p_no_clash;
		(ctrl_data_oe & dev_data_oe) == '0;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");
	a_low_float: assert property (p_low_float) else $error("low lanes still driven");
	a_high_float: assert property (p_high_float) else $error("high lanes still driven");
	a_read_latency: assert property (p_read_latency) else $error("read data late");
	a_data_source: assert property (p_data_source) else $error("data without read");
	a_suspend_hold: assert property (p_suspend_hold) else $error("output moved in suspend");
	a_write_drive: assert property (p_write_drive) else $error("write without data");
	a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
	c_read: cover property (rd);
	c_masked_read: cover property (rd && low_byte_mask);
	c_suspend: cover property (!clock_gate && |dev_data_oe);
endmodule

/* File: dv/tb_sdram_pin_command_interface.sv */
`timescale 1ns/10ps
module tb_sdram_pin_command_interface
	import sdram_pin_pkg::*;
;
	logic core_clk;
	logic nrst;
	logic cmd_valid;
	logic [CMD_W-1:0] cmd_code;
	logic [BANK_W-1:0] cmd_bank;
	logic [ADDR_W-1:0] cmd_addr;
	logic power_save_req;
	logic wr_valid;
	logic [15:0] wr_data;
	logic [MASK_W-1:0] lane_mask;
	logic cmd_refused;
	logic rd_valid;
	logic [15:0] rd_data;
	logic [3:0] rows_open;
	power_state_t power_state;
	logic [ADDR_W-1:0] mode_word;
	logic [3:0] banks_open;
	logic burst_busy;
	int fail_count;
	int checks_done;
	logic [15:0] mem [4];

	sdram_link_if link ();
	sdram_ctrl_end i_sdram_ctrl_end (
		.core_clk,
		.nrst,
		.link(link),
		.cmd_valid,
		.cmd_code,
		.cmd_bank,
		.cmd_addr,
		.power_save_req,
		.wr_valid,
		.wr_data,
		.lane_mask,
		.cmd_refused,
		.rd_valid,
		.rd_data,
		.rows_open
	);
	sdram_device_end i_sdram_device_end (
		.core_clk,
		.nrst,
		.link(link),
		.power_state,
		.mode_word,
		.banks_open,
		.burst_busy
	);
	sdram_pin_command_interface_properties i_sdram_pin_command_interface_properties (
		.core_clk,
		.nrst,
		.clock_gate(link.clock_gate),
		.chip_select_n(link.chip_select_n),
		.row_strobe_n(link.row_strobe_n),
		.col_strobe_n(link.col_strobe_n),
		.write_strobe_n(link.write_strobe_n),
		.low_byte_mask(link.low_byte_mask),
		.high_byte_mask(link.high_byte_mask),
		.ctrl_data_oe(link.ctrl_data_oe),
		.dev_data_oe(link.dev_data_oe)
	);

	initial
	begin
		core_clk = 1'b0;
		forever
			#12.5 core_clk = ~core_clk;
	end

	task automatic finish_test();
		$display("checks %0d fails %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmd(input logic [2:0] c, input int b, input logic [11:0] a,
		input logic [15:0] d = 16'h0000, input logic [1:0] m = 2'h0);
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_bank <= 2'(b);
		cmd_addr <= a;
		wr_valid <= c == CMD_WRITE;
		wr_data <= d;
		lane_mask <= m;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		wr_valid <= 1'b0;
		lane_mask <= 2'h0;
	endtask

	// read and wait for the returned beat
	task automatic rd(input int b, input logic [11:0] a, input logic [15:0] e,
		input logic [1:0] m = 2'h0);
		int i;
		cmd(CMD_READ, b, a, 16'h0000, m);
		i = 0;
		do
		begin
			@(negedge core_clk);
			i++;
		end
		while (rd_valid !== 1'b1 && i < 12);
		if (rd_valid !== 1'b1)
		begin
			fail_count++;
			finish_test();
		end
		else
			chk(rd_data, e);
	endtask

	task automatic pd(input power_state_t e, input bit sr);
		int i;
		@(posedge core_clk);
		power_save_req <= 1'b1;
		cmd_valid <= sr;
		cmd_code <= CMD_REFRESH;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		repeat (4) @(negedge core_clk);
		chk(16'(power_state), 16'(e));
		@(posedge core_clk);
		power_save_req <= 1'b0;
		repeat (2) @(negedge core_clk);
		chk(16'(power_state !== PS_RUN), 16'h0001);
		i = 0;
		do
		begin
			@(negedge core_clk);
			i++;
		end
		while (power_state !== PS_RUN && i < 10);
		chk(16'(power_state), 16'(PS_RUN));
	endtask

	initial
	begin
		int n;
		logic p;
		nrst = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = CMD_NOP;
		cmd_bank = 2'h0;
		cmd_addr = 12'h000;
		power_save_req = 1'b0;
		wr_valid = 1'b0;
		wr_data = 16'h0000;
		lane_mask = 2'h0;
		fail_count = 0;
		checks_done = 0;
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		@(negedge core_clk);
		chk(16'(power_state), 16'(PS_RUN));
		chk(16'(mode_word), 16'h0020);
		chk(16'(banks_open), 16'h0000);
		cmd(CMD_READ, 1, 12'h003);
		n = 0;
		repeat (3)
		begin
			@(negedge core_clk);
			n += cmd_refused;
		end
		chk(16'(n), 16'h0001);
		for (int b = 0; b < 4; b++)
			cmd(CMD_ACTIVATE, b, 12'h005 + 12'(b));
		repeat (2) @(negedge core_clk);
		chk(16'(banks_open), 16'h000F);
		chk(16'(rows_open), 16'h000F);
		for (int b = 0; b < 4; b++)
		begin
			mem[b] = 16'h1357 ^ {4{4'(b)}};
			cmd(CMD_WRITE, b, 12'h003, mem[b]);
		end
		for (int b = 0; b < 4; b++)
			rd(b, 12'h003, mem[b]);
		cmd(CMD_WRITE, 2, 12'h003, 16'hFFFF, 2'h1);
		rd(2, 12'h003, {8'hFF, mem[2][7:0]});
		rd(2, 12'h003, {8'hFF, 8'h00}, 2'h1);
		rd(2, 12'h003, {8'h00, mem[2][7:0]}, 2'h2);
		rd(3, 12'h403, mem[3]);
		chk(16'(banks_open), 16'h0007);
		chk(16'(rows_open), 16'h0007);
		cmd(CMD_PRECHARGE, 0, 12'h000);
		repeat (2) @(negedge core_clk);
		chk(16'(banks_open), 16'h0006);
		cmd(CMD_PRECHARGE, 0, 12'h400);
		repeat (2) @(negedge core_clk);
		chk(16'(banks_open), 16'h0000);
		cmd(CMD_LOAD_MODE, 0, 12'h022);
		repeat (2) @(negedge core_clk);
		chk(16'(mode_word), 16'h0022);
		cmd(CMD_ACTIVATE, 1, 12'h006);
		// four-beat read, second time frozen for two cycles
		for (int s = 0; s < 2; s++)
		begin
			cmd(CMD_READ, 1, 12'h000);
			power_save_req <= s[0];
			n = 0;
			p = 1'b0;
			for (int i = 0; i < 12; i++)
			begin
				@(posedge core_clk);
				if (i == 1)
					power_save_req <= 1'b0;
				@(negedge core_clk);
				n += burst_busy;
				p |= power_state == PS_SUSPEND;
			end
			chk(16'(n), s ? 16'h0005 : 16'h0003);
			chk(16'(p), 16'(s));
		end
		pd(PS_ACT_PD, 1'b0);
		cmd(CMD_PRECHARGE, 0, 12'h400);
		pd(PS_PRE_PD, 1'b0);
		pd(PS_SELF_REF, 1'b1);
		finish_test();
	end
endmodule

/* File: hw/sdram_ctrl_end.sv */
`timescale 1ns/10ps
module sdram_ctrl_end
	import sdram_pin_pkg::*;
#(
	parameter int DATA_W = DQ_W_DEFAULT,
	parameter bit USE_POWER_SAVE = 1'b1
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// pins facing the memory
	sdram_link_if.ctrl link,
	// command request
	input wire logic cmd_valid,
	input wire logic [CMD_W-1:0] cmd_code,
	input wire logic [BANK_W-1:0] cmd_bank,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic power_save_req,
	// write data and masks
	input wire logic wr_valid,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic [MASK_W-1:0] lane_mask,
	// answers
	output logic cmd_refused,
	output logic rd_valid,
	output logic [DATA_W-1:0] rd_data,
	output logic [NUM_BANKS-1:0] rows_open
);

	logic is_access;
	logic refuse;
	assign is_access = cmd_code == CMD_READ || cmd_code == CMD_WRITE;
	assign refuse = cmd_valid && is_access && !rows_open[cmd_bank];

	// command pins, all from one register stage
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			link.clock_gate <= 1'b1;
			link.chip_select_n <= 1'b1;
			{link.row_strobe_n, link.col_strobe_n, link.write_strobe_n} <= CMD_NOP;
			link.bank_select <= '0;
			link.address_bus <= '0;
		end
		else
		begin
			link.clock_gate <= USE_POWER_SAVE ? !power_save_req : 1'b1;
			link.chip_select_n <= 1'b0;
			if (cmd_valid && !refuse)
			begin
				{link.row_strobe_n, link.col_strobe_n, link.write_strobe_n} <= cmd_code;
				link.bank_select <= cmd_bank;
				link.address_bus <= cmd_addr;
			end
			else
				{link.row_strobe_n, link.col_strobe_n, link.write_strobe_n} <= CMD_NOP;
		end
	end

	// open-row tracking
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			rows_open <= '0;
		else if (cmd_valid && !refuse)
		begin
			if (cmd_code == CMD_ACTIVATE)
				rows_open[cmd_bank] <= 1'b1;
			else if (cmd_code == CMD_PRECHARGE && cmd_addr[PRE_SCOPE_BIT])
				rows_open <= '0;
			else if (cmd_code == CMD_PRECHARGE || (is_access && cmd_addr[PRE_SCOPE_BIT]))
				rows_open[cmd_bank] <= 1'b0;
		end
	end

	// data and masks
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			link.ctrl_data_out <= '0;
			link.ctrl_data_oe <= '0;
			link.low_byte_mask <= 1'b0;
			link.high_byte_mask <= 1'b0;
			cmd_refused <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= '0;
		end
		else
		begin
			link.ctrl_data_out <= wr_data;
			link.ctrl_data_oe <= wr_valid ? '1 : '0;
			link.low_byte_mask <= lane_mask[0];
			link.high_byte_mask <= lane_mask[1];
			cmd_refused <= refuse;
			rd_valid <= |link.dev_data_oe;
			rd_data <= link.data_lines;
		end
	end

endmodule

/* File: hw/sdram_device_end.sv */
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// - all inputs sampled on rising clock only
// - clock advances burst counter, read output registers
// - gate low enters power-down, self refresh, suspend
// - gate asynchronous from power-down entry until exit
// - input buffers disabled in power-down, self refresh
// - controller may tie clock gate high
// - commands accepted only with chip select low
// - deselect keeps burst running and masks active
// - select plus three strobes encode the command
// - masked write lanes leave memory unchanged
// - read mask floats lanes two cycles later
// - sixteen-bit splits masks, narrower uses one
// - bank select names the target bank
// - activate takes twelve address bits as row
// - column bits depend on data width
// - bit ten on read/write selects auto-precharge
// - precharge bit ten selects all or one bank
// - load mode takes address as op-code
// - activate must open row before read/write
module sdram_device_end
	import sdram_pin_pkg::*;
#(
	parameter int DATA_W = DQ_W_DEFAULT,
	parameter int MEM_ROW_W = 2,
	parameter int MEM_COL_W = 4
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// pins facing the controller
	sdram_link_if.mem link,
	// status
	output power_state_t power_state,
	output logic [ADDR_W-1:0] mode_word,
	output logic [NUM_BANKS-1:0] banks_open,
	output logic burst_busy
);

	localparam int MEM_AW = BANK_W + MEM_ROW_W + MEM_COL_W;
	localparam int MEM_DEPTH = 1 << MEM_AW;
	localparam int PIPE_N = CL_MAX - 1;

	function automatic logic [COL_MAX_W-1:0] column_of(input logic [ADDR_W-1:0] a);
		logic [COL_MAX_W-1:0] c;
		c = '0;
		if (DATA_W == DQ_W_X4)
			c = {a[COL_EXT_BIT], a[COL_X8_W-1:0]};
		else if (DATA_W == DQ_W_X8)
			c[COL_X8_W-1:0] = a[COL_X8_W-1:0];
		else
			c[COL_X16_W-1:0] = a[COL_X16_W-1:0];
		return c;
	endfunction

	// per-bit mask from {high, low}
	function automatic logic [DATA_W-1:0] lane_bits(input logic [MASK_W-1:0] m);
		logic [DATA_W-1:0] b;
		b = '0;
		for (int i = 0; i < DATA_W; i++)
			b[i] = (DATA_W == DQ_W_X16 && i < BYTE_W) ? m[0] : m[1];
		return b;
	endfunction

	function automatic int cas_latency(input logic [ADDR_W-1:0] mw);
		int v;
		v = int'(mw[CL_LSB +: CL_W]);
		if (v < 1 || v > CL_MAX)
			v = CL_MAX;
		return v;
	endfunction

	// sampled pins
	logic [CMD_W-1:0] cmd;
	logic [MASK_W-1:0] mask_in;
	logic active;
	logic cmd_ok;
	logic start_rd;
	logic start_wr;
	logic start_burst;
	assign cmd = {link.row_strobe_n, link.col_strobe_n, link.write_strobe_n};
	assign mask_in = {link.high_byte_mask, link.low_byte_mask};
	// suspend exit edge already runs, so a suspend costs only the gated cycles
	assign active = (power_state == PS_RUN || power_state == PS_SUSPEND) &&
		link.clock_gate;
	assign cmd_ok = active && !link.chip_select_n;
	assign start_rd = cmd_ok && cmd == CMD_READ;
	assign start_wr = cmd_ok && cmd == CMD_WRITE;
	assign start_burst = start_rd || start_wr;

	// burst state
	logic burst_write;
	logic burst_autopre;
	logic burst_full;
	logic [BANK_W-1:0] burst_bank;
	logic [COL_MAX_W-1:0] burst_col;
	logic [BEATS_W-1:0] beats_left;
	logic [ADDR_W-1:0] open_row [NUM_BANKS];
	logic [DATA_W-1:0] mem [MEM_DEPTH];

	logic [BL_W-1:0] bl_code;
	logic new_full;
	logic [BEATS_W-1:0] new_len;
	assign bl_code = mode_word[BL_LSB +: BL_W];
	assign new_full = (bl_code == BL_CODE_PAGE) && !(start_wr && mode_word[WB_BIT]);
	assign new_len = (bl_code > BL_CODE_MAX || (start_wr && mode_word[WB_BIT])) ?
		BEATS_W'(1) : BEATS_W'(1) << bl_code;

	logic beat_on;
	logic beat_write;
	logic beat_autopre;
	logic last_beat;
	logic [BANK_W-1:0] beat_bank;
	logic [COL_MAX_W-1:0] beat_col;
	logic [MEM_AW-1:0] beat_index;
	logic [ADDR_W-1:0] beat_row;
	assign beat_on = start_burst || (active && burst_busy);
	assign beat_write = start_burst ? start_wr : burst_write;
	assign beat_bank = start_burst ? link.bank_select : burst_bank;
	assign beat_col = start_burst ? column_of(link.address_bus) : burst_col;
	assign beat_autopre = start_burst ? link.address_bus[PRE_SCOPE_BIT] : burst_autopre;
	assign last_beat = start_burst ? (new_len == BEATS_W'(1) && !new_full) :
		(beats_left == BEATS_W'(1) && !burst_full);
	assign beat_row = open_row[beat_bank];
	assign beat_index = {beat_bank, beat_row[MEM_ROW_W-1:0], beat_col[MEM_COL_W-1:0]};

	logic pre_cmd;
	logic pre_hits_burst;
	assign pre_cmd = cmd_ok && cmd == CMD_PRECHARGE;
	assign pre_hits_burst = pre_cmd &&
		(link.address_bus[PRE_SCOPE_BIT] || link.bank_select == burst_bank);

	// burst counter
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			burst_busy <= 1'b0;
			burst_write <= 1'b0;
			burst_autopre <= 1'b0;
			burst_full <= 1'b0;
			burst_bank <= '0;
			burst_col <= '0;
			beats_left <= '0;
		end
		else if ((cmd_ok && cmd == CMD_BURST_STOP) || (pre_hits_burst && !start_burst))
			burst_busy <= 1'b0;
		else if (beat_on)
		begin
			burst_busy <= !last_beat;
			burst_col <= beat_col + COL_MAX_W'(1);
			beats_left <= start_burst ? new_len - BEATS_W'(1) : beats_left - BEATS_W'(1);
			if (start_burst)
			begin
				burst_write <= start_wr;
				burst_bank <= link.bank_select;
				burst_autopre <= link.address_bus[PRE_SCOPE_BIT];
				burst_full <= new_full;
			end
		end
	end

	// bank rows
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			banks_open <= '0;
		else if (active)
		begin
			if (cmd_ok && cmd == CMD_ACTIVATE)
			begin
				banks_open[link.bank_select] <= 1'b1;
				open_row[link.bank_select] <= link.address_bus;
			end
			if (pre_cmd)
			begin
				if (link.address_bus[PRE_SCOPE_BIT])
					banks_open <= '0;
				else
					banks_open[link.bank_select] <= 1'b0;
			end
			if (beat_on && last_beat && beat_autopre)
				banks_open[beat_bank] <= 1'b0;
		end
	end

	// mode word
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			mode_word <= MODE_RESET;
		else if (cmd_ok && cmd == CMD_LOAD_MODE)
			mode_word <= link.address_bus;
	end

	// array writes, masked lanes untouched
	logic [DATA_W-1:0] wr_keep;
	assign wr_keep = lane_bits(mask_in);
	always_ff @(posedge core_clk)
	begin
		if (beat_on && beat_write)
			for (int i = 0; i < DATA_W; i++)
				if (!wr_keep[i])
					mem[beat_index][i] <= link.data_lines[i];
	end

	// read latency pipe
	logic rd_valid_pipe [PIPE_N];
	logic [DATA_W-1:0] rd_data_pipe [PIPE_N];
	logic [MASK_W-1:0] mask_d1;
	logic tap_valid;
	logic [DATA_W-1:0] tap_data;
	int cl;
	assign cl = cas_latency(mode_word);

	always_comb
	begin
		tap_valid = beat_on && !beat_write;
		tap_data = mem[beat_index];
		if (cl > 1)
		begin
			tap_valid = rd_valid_pipe[cl-2];
			tap_data = rd_data_pipe[cl-2];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			for (int k = 0; k < PIPE_N; k++)
				rd_valid_pipe[k] <= 1'b0;
			mask_d1 <= '0;
		end
		else if (active)
		begin
			rd_valid_pipe[0] <= beat_on && !beat_write;
			rd_data_pipe[0] <= mem[beat_index];
			for (int k = 1; k < PIPE_N; k++)
			begin
				rd_valid_pipe[k] <= rd_valid_pipe[k-1];
				rd_data_pipe[k] <= rd_data_pipe[k-1];
			end
			mask_d1 <= mask_in;
		end
	end

	// output registers, frozen in clock suspend
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			link.dev_data_out <= '0;
			link.dev_data_oe <= '0;
		end
		else if (active)
		begin
			link.dev_data_out <= tap_data;
			link.dev_data_oe <= tap_valid ? ~lane_bits(mask_d1) : '0;
		end
		else if (power_state != PS_RUN && power_state != PS_SUSPEND)
			link.dev_data_oe <= '0;
	end

	// gate watched without clock qualification while powered down
	logic gate_s1;
	logic gate_s2;
	logic gate_s3;
	logic wake_armed;
	logic wake;
	assign wake = wake_armed && gate_s2 && gate_s3;

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			gate_s1 <= 1'b1;
			gate_s2 <= 1'b1;
			gate_s3 <= 1'b1;
		end
		else
		begin
			gate_s1 <= link.clock_gate;
			gate_s2 <= gate_s1;
			gate_s3 <= gate_s2;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst || power_state == PS_RUN || power_state == PS_SUSPEND)
			wake_armed <= 1'b0;
		else if (!gate_s2 && !gate_s3)
			wake_armed <= 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			power_state <= PS_RUN;
		else
			unique case (power_state)
				PS_RUN:
					if (!link.clock_gate)
					begin
						if (burst_busy)
							power_state <= PS_SUSPEND;
						else if (|banks_open)
							power_state <= PS_ACT_PD;
						else if (!link.chip_select_n && cmd == CMD_REFRESH)
							power_state <= PS_SELF_REF;
						else
							power_state <= PS_PRE_PD;
					end
				PS_SUSPEND:
					if (link.clock_gate)
						power_state <= PS_RUN;
				PS_ACT_PD, PS_PRE_PD, PS_SELF_REF:
					if (wake)
						power_state <= PS_RUN;
			endcase
	end

endmodule

/* File: hw/sdram_link_if.sv */
`timescale 1ns/10ps
interface sdram_link_if
	import sdram_pin_pkg::*;
#(
	parameter int DATA_W = DQ_W_DEFAULT
);
	logic clock_gate;
	logic chip_select_n;
	logic row_strobe_n;
	logic col_strobe_n;
	logic write_strobe_n;
	logic [BANK_W-1:0] bank_select;
	logic [ADDR_W-1:0] address_bus;
	logic low_byte_mask;
	logic high_byte_mask;
	logic [DATA_W-1:0] ctrl_data_out;
	logic [DATA_W-1:0] ctrl_data_oe;
	logic [DATA_W-1:0] dev_data_out;
	logic [DATA_W-1:0] dev_data_oe;
	logic [DATA_W-1:0] data_lines;

	// wire level of the shared data lines, undriven bits read low
	assign data_lines = (dev_data_out & dev_data_oe) | (ctrl_data_out & ctrl_data_oe);

	modport mem (
		input clock_gate, chip_select_n, row_strobe_n, col_strobe_n, write_strobe_n,
		input bank_select, address_bus, low_byte_mask, high_byte_mask, data_lines,
		output dev_data_out, dev_data_oe
	);

	modport ctrl (
		output clock_gate, chip_select_n, row_strobe_n, col_strobe_n, write_strobe_n,
		output bank_select, address_bus, low_byte_mask, high_byte_mask,
		output ctrl_data_out, ctrl_data_oe,
		input data_lines, dev_data_oe
	);
endinterface

/* File: hw/sdram_pin_pkg.sv */
package sdram_pin_pkg;

	// pin widths
	localparam int ADDR_W = 12;
	localparam int BANK_W = 2;
	localparam int NUM_BANKS = 4;
	localparam int CMD_W = 3;
	localparam int MASK_W = 2;
	localparam int BYTE_W = 8;

	// data width configurations
	localparam int DQ_W_X4 = 4;
	localparam int DQ_W_X8 = 8;
	localparam int DQ_W_X16 = 16;
	localparam int DQ_W_DEFAULT = DQ_W_X16;

	// address bit roles
	localparam int PRE_SCOPE_BIT = 10;
	localparam int COL_EXT_BIT = 11;
	localparam int COL_MAX_W = 11;
	localparam int COL_X8_W = 10;
	localparam int COL_X16_W = 9;

	// command codes as {row strobe, column strobe, write strobe}, all active low
	localparam logic [CMD_W-1:0] CMD_LOAD_MODE = 3'h0;
	localparam logic [CMD_W-1:0] CMD_REFRESH = 3'h1;
	localparam logic [CMD_W-1:0] CMD_PRECHARGE = 3'h2;
	localparam logic [CMD_W-1:0] CMD_ACTIVATE = 3'h3;
	localparam logic [CMD_W-1:0] CMD_WRITE = 3'h4;
	localparam logic [CMD_W-1:0] CMD_READ = 3'h5;
	localparam logic [CMD_W-1:0] CMD_BURST_STOP = 3'h6;
	localparam logic [CMD_W-1:0] CMD_NOP = 3'h7;

	// mode word fields
	localparam int BL_LSB = 0;
	localparam int BL_W = 3;
	localparam int CL_LSB = 4;
	localparam int CL_W = 3;
	localparam int WB_BIT = 9;
	localparam logic [BL_W-1:0] BL_CODE_MAX = 3'h3;
	localparam logic [BL_W-1:0] BL_CODE_PAGE = 3'h7;
	localparam logic [ADDR_W-1:0] MODE_RESET = 12'h020;
	localparam int CL_MAX = 3;
	localparam int BEATS_W = 4;

	typedef enum logic [4:0] {
		PS_RUN = 5'h01,
		PS_SUSPEND = 5'h02,
		PS_ACT_PD = 5'h04,
		PS_PRE_PD = 5'h08,
		PS_SELF_REF = 5'h10
	} power_state_t;

endpackage
